/* File: inc/scpm_regs.svh */
// constants shared by the sync/clock pin multiplexer ends
// assumes inclusion by bare name from inc/
`ifndef SCPM_REGS_SVH
`define SCPM_REGS_SVH
// ==========================================
// device register offsets and resets
`define SCPM_STATUS_ADR   8'h04
`define SCPM_DATA_ADR     8'h08
`define SCPM_FILTER_ADR   8'h28
`define SCPM_INTMAP_ADR   8'h2A
`define SCPM_SYNC_ADR     8'h2B
`define SCPM_RANGE_ADR    8'h2C
`define SCPM_POWER_ADR    8'h2D
`define SCPM_DIAG_ADR     8'h2E
`define SCPM_RESET_ADR    8'h2F
`define SCPM_RANGE_RST    8'h81
`define SCPM_POWER_RST    8'h01
`define SCPM_HPF_MASK     8'h70
`define SCPM_DIAG_MASK    8'h03
`define SCPM_SYNC_MASK    8'h07
`define SCPM_RESET_CODE   8'h52
`define SCPM_OUTCLK_BIT   2
`define SCPM_STANDBY_BIT  0
`define SCPM_POL_BIT      6
// ==========================================
// host register offsets and fields
`define SCPM_H_CTRL_ADR   8'h00
`define SCPM_H_CMD_ADR    8'h04
`define SCPM_H_WDATA_ADR  8'h08
`define SCPM_H_STAT_ADR   8'h0C
`define SCPM_H_RDYCNT_ADR 8'h10
`define SCPM_CTRL_EXTCLK  0
`define SCPM_CTRL_STROBE  1
`define SCPM_CTRL_SYNCDRV 2
`define SCPM_CMD_RD_BIT   8
`define SCPM_ST_STROBE    2
// ==========================================
// timing
`define SCPM_HCLK_KHZ     40000
`define SCPM_OUTSIDE_CLOCK_SEL_KHZ  1024
`define SCPM_EXT_HALF_CYC (`SCPM_HCLK_KHZ / (2 * `SCPM_OUTSIDE_CLOCK_SEL_KHZ))
`define SCPM_STROBE_MIN_NS 3910
`define SCPM_STROBE_CYC   ((`SCPM_STROBE_MIN_NS * `SCPM_HCLK_KHZ + 999999) / 1000000)
`define SCPM_STROBE_HOLD  (`SCPM_STROBE_CYC + 2 * `SCPM_EXT_HALF_CYC)
`define SCPM_STROBE_EDGES 4
`endif

/* File: inc/scpm_pkg.sv */
// types shared by the sync/clock pin multiplexer ends
// assumes nothing beyond a SystemVerilog compiler
package scpm_pkg;
    typedef enum logic [1:0] {
        SCPM_SYNC_NONE   = 2'h0,
        SCPM_SYNC_ALIGN  = 2'h1,
        SCPM_SYNC_INTERP = 2'h2
    } scpm_sync_t;
    typedef enum logic [1:0] {
        SCPM_STB_IDLE = 2'h1,
        SCPM_STB_HOLD = 2'h2
    } scpm_stb_t;
endpackage

/* File: inc/scpm_if.sv */
// link between the controller end and the sensor end
// assumes lclk comes from the bench; pins resolve with a weak pull-down
`timescale 1ns/1ps
interface scpm_if (
    input wire logic lclk
);
    logic       cfg_req_tgl;
    logic       cfg_rd;
    logic [7:0] cfg_addr;
    logic [7:0] cfg_wdata;
    logic       cfg_ack_tgl;
    logic [7:0] cfg_rdata;
    logic       irq2_dev_o;
    logic       irq2_dev_oe_n;
    logic       irq2_host_o;
    logic       irq2_host_oe_n;
    logic       rdy_dev_o;
    logic       rdy_dev_oe_n;
    logic       rdy_host_o;
    logic       rdy_host_oe_n;
    logic       second_irq_pin;
    logic       sample_ready_pin;
    // ==========================================
    // pin resolution; undriven reads low
    assign second_irq_pin = !irq2_dev_oe_n ? irq2_dev_o :
                            !irq2_host_oe_n ? irq2_host_o : 1'b0;
    assign sample_ready_pin = !rdy_dev_oe_n ? rdy_dev_o :
                              !rdy_host_oe_n ? rdy_host_o : 1'b0;
    modport dev (
        input  lclk, cfg_req_tgl, cfg_rd, cfg_addr, cfg_wdata,
        input  second_irq_pin, sample_ready_pin,
        output cfg_ack_tgl, cfg_rdata,
        output irq2_dev_o, irq2_dev_oe_n, rdy_dev_o, rdy_dev_oe_n
    );
    modport host (
        output cfg_req_tgl, cfg_rd, cfg_addr, cfg_wdata,
        input  second_irq_pin, sample_ready_pin,
        input  cfg_ack_tgl, cfg_rdata,
        output irq2_host_o, irq2_host_oe_n, rdy_host_o, rdy_host_oe_n
    );
endinterface

/* File: src/scpm_dev.sv */
// sensor end: pin multiplexing of the second irq and sample-ready pins,
// external clock and sync strobe handling, config write restrictions
// assumes lclk is its own oscillator; config arrives by toggle handshake
//
// Behaviour
// RL1: sync 01 plus outside clock uses pins
// RL2: no outside clock: no samples, null data
// RL3: host holds strobe four clock periods
// RL4: before first strobe run at internal rate
// RL5: timing stays aligned to latest strobe
// RL6: sync 10 gives one sample per strobe
// RL7: internal mode: irq2 low or irq, ready out
// RL8: outside clock: irq2 pin only clock input
// RL9: sync modes: ready pin input, irq2 muxed
// RL10: sync 01 internal clock resets filter
// RL11: sync 01 outside clock: delayed data
// RL12: host writes config before measuring
// RL13: measuring accepts only few register changes
// RL14: ready output active high, polarity-free
// RL15: strobe valid after four high edges
`timescale 1ns/1ps
`include "scpm_regs.svh"
module scpm_dev #(
    parameter int BASE_CYC = 16,
    parameter int LOSS_CYC = 16,
    parameter int GRP_DLY  = 3
) (
    // link
    scpm_if.dev      lnk,
    // reset and status
    input  wire logic       hresetn,
    output logic            measuring_ff,
    output logic [7:0]      data_out_ff
);
    logic [1:0]  rst_pipe_ff;
    logic [7:0]  filter_ff, intmap_ff, sync_ff, range_ff, power_ff, diag_ff;
    logic        req_s1_ff, req_s2_ff, req_s3_ff, ack_ff;
    logic [7:0]  rdata_ff, gap_ff, acc_ff;
    logic        rst_n, i2_s1_ff, i2_s2_ff, i2_s3_ff;
    logic        rp_s1_ff, rp_s2_ff, synced_ff, rdy_ff;
    logic [2:0]  hi_cnt_ff;
    logic [19:0] phase_ff;
    logic [7:0]  hist_ff [GRP_DLY];
    logic        i2_o_ff, i2_oe_n_ff, rp_o_ff, rp_oe_n_ff;

    // ==========================================
    // reset release in the link domain
    always_ff @(posedge lnk.lclk or negedge hresetn) begin
        if (!hresetn) rst_pipe_ff <= 2'h0;
        else rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
    assign rst_n = rst_pipe_ff[1];

    // ==========================================
    // decode
    scpm_pkg::scpm_sync_t mode;
    wire        outside  = sync_ff[`SCPM_OUTCLK_BIT];
    wire        meas     = ~power_ff[`SCPM_STANDBY_BIT];
    wire        take     = req_s2_ff ^ req_s3_ff;
    wire        wr       = take & ~lnk.cfg_rd;
    wire        rd       = take & lnk.cfg_rd;
    wire [7:0]  wa       = lnk.cfg_addr;
    wire [7:0]  wd       = lnk.cfg_wdata;
    wire        soft_rst = wr && wa == `SCPM_RESET_ADR && wd == `SCPM_RESET_CODE;
    // RL13 measuring locks
    wire        open_cfg = wr & ~meas;
    wire        ext_tick = outside & i2_s2_ff & ~i2_s3_ff;
    // RL2 clock loss
    wire        alive    = gap_ff < 8'(LOSS_CYC);
    wire        tick     = outside ? (ext_tick & alive) : 1'b1;
    wire [19:0] period   = 20'(BASE_CYC) << filter_ff[3:0];
    // RL15 four high edges
    wire        strobe   = tick && mode != scpm_pkg::SCPM_SYNC_NONE && rp_s2_ff &&
                           hi_cnt_ff == 3'(`SCPM_STROBE_EDGES - 1);
    wire        wrap     = phase_ff == period - 20'h1;
    // RL4 internal rate until strobe
    // RL6 strobe-paced interpolation
    wire        sample   = meas & (mode == scpm_pkg::SCPM_SYNC_INTERP ?
                           (strobe | (tick & wrap & ~synced_ff)) : (tick & wrap));
    wire        data_rd  = rd && wa == `SCPM_DATA_ADR;
    // RL11 group-delayed word
    wire [7:0]  cur_data = (mode == scpm_pkg::SCPM_SYNC_ALIGN && outside) ?
                           hist_ff[GRP_DLY-1] : hist_ff[0];
    // RL2 null reads
    wire [7:0]  out_data = (outside & ~alive) ? 8'h00 : cur_data;
    wire [7:0]  status   = {5'h0, alive, synced_ff, rdy_ff};
    wire [7:0]  rd_mux   = wa == `SCPM_STATUS_ADR ? status :
                           wa == `SCPM_DATA_ADR   ? out_data :
                           wa == `SCPM_FILTER_ADR ? filter_ff :
                           wa == `SCPM_INTMAP_ADR ? intmap_ff :
                           wa == `SCPM_SYNC_ADR   ? sync_ff :
                           wa == `SCPM_RANGE_ADR  ? range_ff :
                           wa == `SCPM_POWER_ADR  ? power_ff :
                           wa == `SCPM_DIAG_ADR   ? diag_ff : 8'h00;
    assign mode = scpm_pkg::scpm_sync_t'(sync_ff[1:0]);

    // ==========================================
    // config handshake and registers
    always_ff @(posedge lnk.lclk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
            ack_ff    <= 1'b0;
            rdata_ff  <= 8'h00;
        end else begin
            req_s1_ff <= lnk.cfg_req_tgl;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
            ack_ff    <= ack_ff ^ take;
            if (rd) rdata_ff <= rd_mux;
        end
    end

    always_ff @(posedge lnk.lclk or negedge rst_n) begin
        if (!rst_n) begin
            filter_ff <= 8'h00;
            intmap_ff <= 8'h00;
            sync_ff   <= 8'h00;
            range_ff  <= `SCPM_RANGE_RST;
            power_ff  <= `SCPM_POWER_RST;
            diag_ff   <= 8'h00;
        end else if (soft_rst) begin
            filter_ff <= 8'h00;
            intmap_ff <= 8'h00;
            sync_ff   <= 8'h00;
            range_ff  <= `SCPM_RANGE_RST;
            power_ff  <= `SCPM_POWER_RST;
            diag_ff   <= 8'h00;
        end else if (wr) begin
            // RL13 corner bits always open
            if (wa == `SCPM_FILTER_ADR)
                filter_ff <= meas ? ((filter_ff & ~`SCPM_HPF_MASK) | (wd & `SCPM_HPF_MASK))
                                  : wd;
            if (wa == `SCPM_INTMAP_ADR) intmap_ff <= wd;
            if (wa == `SCPM_DIAG_ADR)   diag_ff <= wd & `SCPM_DIAG_MASK;
            if (wa == `SCPM_POWER_ADR)  power_ff <= wd;
            if (open_cfg && wa == `SCPM_SYNC_ADR)  sync_ff <= wd & `SCPM_SYNC_MASK;
            if (open_cfg && wa == `SCPM_RANGE_ADR) range_ff <= wd;
        end
    end

    // ==========================================
    // pin inputs, two flops before use
    // RL1 outside clock and strobe inputs
    always_ff @(posedge lnk.lclk or negedge rst_n) begin
        if (!rst_n) begin
            i2_s1_ff <= 1'b0;
            i2_s2_ff <= 1'b0;
            i2_s3_ff <= 1'b0;
            rp_s1_ff <= 1'b0;
            rp_s2_ff <= 1'b0;
        end else begin
            i2_s1_ff <= lnk.second_irq_pin;
            i2_s2_ff <= i2_s1_ff;
            i2_s3_ff <= i2_s2_ff;
            rp_s1_ff <= lnk.sample_ready_pin;
            rp_s2_ff <= rp_s1_ff;
        end
    end

    // ==========================================
    // clock watch, strobe qualify, output timing
    always_ff @(posedge lnk.lclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff    <= 8'(LOSS_CYC);
            hi_cnt_ff <= 3'h0;
            phase_ff  <= 20'h0;
            synced_ff <= 1'b0;
            acc_ff    <= 8'h00;
        end else begin
            if (ext_tick) gap_ff <= 8'h00;
            else if (alive) gap_ff <= gap_ff + 8'h1;
            // RL15 count consecutive highs
            if (tick) begin
                if (!rp_s2_ff) hi_cnt_ff <= 3'h0;
                else if (hi_cnt_ff != 3'(`SCPM_STROBE_EDGES)) hi_cnt_ff <= hi_cnt_ff + 3'h1;
            end
            // RL5 realign on each strobe
            if (strobe || !meas) phase_ff <= 20'h0;
            else if (tick) phase_ff <= wrap ? 20'h0 : phase_ff + 20'h1;
            if (!meas || mode == scpm_pkg::SCPM_SYNC_NONE) synced_ff <= 1'b0;
            else if (strobe) synced_ff <= 1'b1;
            // RL10 filter restart on strobe
            if (strobe && mode == scpm_pkg::SCPM_SYNC_ALIGN && !outside) acc_ff <= 8'h00;
            else if (tick && meas) acc_ff <= acc_ff + 8'h1;
        end
    end

    // sample history; depth sets the group delay seen in aligned mode with outside clock
    genvar gi;
    for (gi = 0; gi < GRP_DLY; gi++) begin : g_hist
        always_ff @(posedge lnk.lclk or negedge rst_n) begin
            if (!rst_n) hist_ff[gi] <= 8'h00;
            else if (sample) hist_ff[gi] <= (gi == 0) ? acc_ff : hist_ff[(gi == 0) ? 0 : gi-1];
        end
    end

    // ==========================================
    // ready flag and pin multiplexing
    wire map_zero = intmap_ff[7:4] == 4'h0;
    // second irq carries only ready among modelled events; polarity applies
    wire irq2     = (intmap_ff[4] & rdy_ff) ^ range_ff[`SCPM_POL_BIT];
    wire autoclr  = phase_ff == (period >> 1);
    wire sync_in     = mode != scpm_pkg::SCPM_SYNC_NONE;
    // RL8 clock input only
    wire nxt_i2_oe_n = outside;
    // RL7 low or second irq
    // RL9 ready moves to irq2 pin
    wire nxt_i2_o    = map_zero ? (sync_in & rdy_ff) : irq2;
    // RL9 ready pin becomes input
    wire nxt_rp_oe_n = sync_in;

    always_ff @(posedge lnk.lclk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_ff       <= 1'b0;
            i2_o_ff      <= 1'b0;
            i2_oe_n_ff   <= 1'b1;
            rp_o_ff      <= 1'b0;
            rp_oe_n_ff   <= 1'b1;
            measuring_ff <= 1'b0;
            data_out_ff  <= 8'h00;
        end else begin
            // RL14 set wins over clear
            if (sample) rdy_ff <= 1'b1;
            else if (data_rd || autoclr) rdy_ff <= 1'b0;
            i2_o_ff      <= nxt_i2_o;
            i2_oe_n_ff   <= nxt_i2_oe_n;
            rp_o_ff      <= rdy_ff;
            rp_oe_n_ff   <= nxt_rp_oe_n;
            measuring_ff <= meas;
            data_out_ff  <= out_data;
        end
    end

    assign lnk.cfg_ack_tgl   = ack_ff;
    assign lnk.cfg_rdata     = rdata_ff;
    assign lnk.irq2_dev_o    = i2_o_ff;
    assign lnk.irq2_dev_oe_n = i2_oe_n_ff;
    assign lnk.rdy_dev_o     = rp_o_ff;
    assign lnk.rdy_dev_oe_n  = rp_oe_n_ff;
endmodule

/* File: src/scpm_host.sv */
// controller end: AHB-Lite slave registers, device access by toggle
// handshake, outside clock divider and sync strobe generator
// assumes hclk at 40 MHz and a single AHB master
`timescale 1ns/1ps
`include "scpm_regs.svh"
module scpm_host (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // link
    scpm_if.host             lnk
);
    logic        ap_wr_ff;
    logic [7:0]  ap_addr_ff;
    logic [31:0] hrdata_ff;
    logic [2:0]  ctrl_ff;
    logic        req_ff, rd_ff, meas_ff, refused_ff;
    logic [7:0]  addr_ff, wdata_ff, rdata_ff;
    logic        ack_s1_ff, ack_s2_ff, ack_s3_ff;
    logic [7:0]  div_ff;
    logic        xclk_ff;
    logic [9:0]  hold_ff;
    logic        rp_s1_ff, rp_s2_ff, rp_s3_ff;
    logic [15:0] rdycnt_ff;
    scpm_pkg::scpm_stb_t stb_ff;

    // ==========================================
    // bus decode; answers with no wait state
    wire ap_take = hsel & htrans[1] & hready;
    wire busy    = req_ff ^ ack_s2_ff;
    wire cmd_wr  = ap_wr_ff && ap_addr_ff == `SCPM_H_CMD_ADR;
    wire cmd_rd  = hwdata[`SCPM_CMD_RD_BIT];
    wire [7:0] ca = hwdata[7:0];
    // RL13 protected while measuring
    wire locked  = meas_ff && !cmd_rd && ca != `SCPM_FILTER_ADR && ca != `SCPM_INTMAP_ADR &&
                   ca != `SCPM_DIAG_ADR && ca != `SCPM_RESET_ADR && ca != `SCPM_POWER_ADR;
    wire refuse  = cmd_wr & (busy | locked);
    wire issue   = cmd_wr & ~refuse;
    wire done    = ack_s2_ff ^ ack_s3_ff;
    wire ctrl_wr = ap_wr_ff && ap_addr_ff == `SCPM_H_CTRL_ADR;
    wire go      = ctrl_wr & hwdata[`SCPM_CTRL_STROBE];
    wire [31:0] status = {16'h0, rdata_ff, 5'h0,
                          stb_ff == scpm_pkg::SCPM_STB_HOLD, refused_ff, busy};
    wire [31:0] rd_mux = haddr == `SCPM_H_CTRL_ADR   ? {29'h0, ctrl_ff} :
                         haddr == `SCPM_H_WDATA_ADR  ? {24'h0, wdata_ff} :
                         haddr == `SCPM_H_STAT_ADR   ? status :
                         haddr == `SCPM_H_RDYCNT_ADR ? {16'h0, rdycnt_ff} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_ff   <= 1'b0;
            ap_addr_ff <= 8'h00;
            hrdata_ff  <= 32'h0;
        end else begin
            ap_wr_ff   <= ap_take & hwrite;
            ap_addr_ff <= haddr;
            if (ap_take && !hwrite) hrdata_ff <= rd_mux;
        end
    end

    // ==========================================
    // device access and shadow of measuring state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff    <= 3'h0;
            req_ff     <= 1'b0;
            rd_ff      <= 1'b0;
            addr_ff    <= 8'h00;
            wdata_ff   <= 8'h00;
            rdata_ff   <= 8'h00;
            meas_ff    <= 1'b0;
            refused_ff <= 1'b0;
            ack_s1_ff  <= 1'b0;
            ack_s2_ff  <= 1'b0;
            ack_s3_ff  <= 1'b0;
        end else begin
            ack_s1_ff <= lnk.cfg_ack_tgl;
            ack_s2_ff <= ack_s1_ff;
            ack_s3_ff <= ack_s2_ff;
            if (ctrl_wr) ctrl_ff <= {hwdata[`SCPM_CTRL_SYNCDRV], 1'b0, hwdata[`SCPM_CTRL_EXTCLK]};
            if (ap_wr_ff && ap_addr_ff == `SCPM_H_WDATA_ADR && !busy) wdata_ff <= hwdata[7:0];
            if (done) rdata_ff <= lnk.cfg_rdata;
            if (refuse) refused_ff <= 1'b1;
            else if (issue) refused_ff <= 1'b0;
            if (issue) begin
                req_ff  <= ~req_ff;
                rd_ff   <= cmd_rd;
                addr_ff <= ca;
                // RL12 measuring starts only by power write
                if (!cmd_rd && ca == `SCPM_POWER_ADR) meas_ff <= ~wdata_ff[`SCPM_STANDBY_BIT];
                if (!cmd_rd && ca == `SCPM_RESET_ADR && wdata_ff == `SCPM_RESET_CODE)
                    meas_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // outside clock and sync strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff  <= 8'h00;
            xclk_ff <= 1'b0;
            hold_ff <= 10'h0;
            stb_ff  <= scpm_pkg::SCPM_STB_IDLE;
        end else begin
            // RL1 divided clock out
            if (!ctrl_ff[`SCPM_CTRL_EXTCLK]) begin
                div_ff  <= 8'h00;
                xclk_ff <= 1'b0;
            end else if (div_ff == 8'(`SCPM_EXT_HALF_CYC - 1)) begin
                div_ff  <= 8'h00;
                xclk_ff <= ~xclk_ff;
            end else div_ff <= div_ff + 8'h1;
            unique case (stb_ff)
                scpm_pkg::SCPM_STB_IDLE: begin
                    hold_ff <= 10'h0;
                    if (go) stb_ff <= scpm_pkg::SCPM_STB_HOLD;
                end
                scpm_pkg::SCPM_STB_HOLD: begin
                    // RL3 four clock periods plus one outside clock period
                    hold_ff <= hold_ff + 10'h1;
                    if (hold_ff == 10'(`SCPM_STROBE_HOLD - 1)) stb_ff <= scpm_pkg::SCPM_STB_IDLE;
                end
                default: stb_ff <= scpm_pkg::SCPM_STB_IDLE;
            endcase
        end
    end

    // ==========================================
    // count ready pulses seen on the sample-ready pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rp_s1_ff  <= 1'b0;
            rp_s2_ff  <= 1'b0;
            rp_s3_ff  <= 1'b0;
            rdycnt_ff <= 16'h0;
        end else begin
            rp_s1_ff <= lnk.sample_ready_pin;
            rp_s2_ff <= rp_s1_ff;
            rp_s3_ff <= rp_s2_ff;
            if (rp_s2_ff && !rp_s3_ff && !ctrl_ff[`SCPM_CTRL_SYNCDRV]) rdycnt_ff <= rdycnt_ff + 16'h1;
        end
    end

    logic hready_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hready_ff <= 1'b0;
        else hready_ff <= 1'b1;
    end

    assign hreadyout          = hready_ff;
    assign hrdata             = hrdata_ff;
    assign hresp              = 1'b0;
    assign lnk.cfg_req_tgl    = req_ff;
    assign lnk.cfg_rd         = rd_ff;
    assign lnk.cfg_addr       = addr_ff;
    assign lnk.cfg_wdata      = wdata_ff;
    assign lnk.irq2_host_o    = xclk_ff;
    assign lnk.irq2_host_oe_n = ~ctrl_ff[`SCPM_CTRL_EXTCLK];
    assign lnk.rdy_host_o     = stb_ff == scpm_pkg::SCPM_STB_HOLD;
    assign lnk.rdy_host_oe_n  = ~ctrl_ff[`SCPM_CTRL_SYNCDRV];
endmodule

/* File: tb/scpm_link_sva.sv */
// link checker: pin drive, toggle handshake, strobe and clock drive
// assumes instantiation beside the interface in the bench top
`timescale 1ns/1ps
module scpm_link_sva (
    // clock and reset
    input wire logic       lclk,
    input wire logic       hresetn,
    // handshake
    input wire logic       cfg_req_tgl,
    input wire logic       cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic       cfg_ack_tgl,
    input wire logic [7:0] cfg_rdata,
    // pin drives
    input wire logic       irq2_dev_oe_n,
    input wire logic       irq2_host_o,
    input wire logic       irq2_host_oe_n,
    input wire logic       rdy_dev_oe_n,
    input wire logic       rdy_host_o,
    input wire logic       rdy_host_oe_n
);
    default clocking cb @(posedge lclk); endclocking
    default disable iff (!hresetn);
    wire pend = cfg_req_tgl != cfg_ack_tgl;
    wire stb  = !rdy_host_oe_n && rdy_host_o;
    // ==========================================
    // a lost pin would short two drivers; these catch it
    property p_irq2_one; !(!irq2_dev_oe_n && !irq2_host_oe_n); endproperty
    a_irq2_one: assert property (p_irq2_one) else $error("irq2 pin driven twice");
    property p_rdy_one; !(!rdy_dev_oe_n && !rdy_host_oe_n); endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready pin driven twice");
    property p_ack_cause; $changed(cfg_ack_tgl) |-> $past(pend); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_req_hold;
        pend && $past(pend) && $stable(cfg_req_tgl) |->
            $stable(cfg_addr) && $stable(cfg_wdata) && $stable(cfg_rd);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved while pending");
    property p_ack_soon; $changed(cfg_req_tgl) |-> ##[1:8] !pend; endproperty
    a_ack_soon: assert property (p_ack_soon) else $error("request unanswered");
    property p_rdata_hold; !pend && $past(!pend) |-> $stable(cfg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved idle");
    property p_stb_width; $rose(stb) |-> stb [*8]; endproperty
    a_stb_width: assert property (p_stb_width) else $error("strobe too short");
    property p_clk_runs;
        !irq2_host_oe_n |-> ##[0:4] ($changed(irq2_host_o) || irq2_host_oe_n);
    endproperty
    a_clk_runs: assert property (p_clk_runs) else $error("outside clock stuck");
    c_stb: cover property ($rose(stb));
    c_clk: cover property ($fell(irq2_host_oe_n));
    c_req: cover property ($changed(cfg_req_tgl) && cfg_rd);
endmodule

/* File: tb/sync_clock_pin_mux_tb.sv */
// bench: AHB master on the controller end, which talks to the sensor end
// assumes hclk 40 MHz and a free-running link clock made here
`timescale 1ns/1ps
`include "scpm_regs.svh"
module sync_clock_pin_mux_tb;
    logic        hclk, lclk, hresetn, hsel, hwrite, hreadyout, hresp, measuring_ff;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  haddr, data_out_ff;
    logic [31:0] hwdata, hrdata, rd;
    int          err_count, cmp_count;
    scpm_if u_scpm_if (.lclk(lclk));
    scpm_host u_scpm_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .lnk(u_scpm_if.host));
    scpm_dev u_scpm_dev (.lnk(u_scpm_if.dev), .hresetn(hresetn),
        .measuring_ff(measuring_ff), .data_out_ff(data_out_ff));
    scpm_link_sva u_scpm_link_sva (.lclk(lclk), .hresetn(hresetn),
        .cfg_req_tgl(u_scpm_if.cfg_req_tgl), .cfg_rd(u_scpm_if.cfg_rd),
        .cfg_addr(u_scpm_if.cfg_addr), .cfg_wdata(u_scpm_if.cfg_wdata),
        .cfg_ack_tgl(u_scpm_if.cfg_ack_tgl), .cfg_rdata(u_scpm_if.cfg_rdata),
        .irq2_dev_oe_n(u_scpm_if.irq2_dev_oe_n), .irq2_host_o(u_scpm_if.irq2_host_o),
        .irq2_host_oe_n(u_scpm_if.irq2_host_oe_n), .rdy_dev_oe_n(u_scpm_if.rdy_dev_oe_n),
        .rdy_host_o(u_scpm_if.rdy_host_o), .rdy_host_oe_n(u_scpm_if.rdy_host_oe_n));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // phase offset keeps the two domains unrelated
    initial begin
        lclk = 1'b0;
        #7;
        forever #80 lclk = ~lclk;
    end
    task automatic results();
        if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic lwait(input int n);
        repeat (n) @(posedge lclk);
        @(posedge hclk);
    endtask
    // device command; rd ends as host status with read data in [15:8]
    task automatic dcmd(input logic r, input logic [7:0] a, input logic [7:0] d);
        ahb(1'b1, `SCPM_H_WDATA_ADR, {24'h0, d});
        ahb(1'b1, `SCPM_H_CMD_ADR, {23'h0, r, a});
        do ahb(1'b0, `SCPM_H_STAT_ADR, 32'h0);
        while (rd[0] !== 1'b0);
        ahb(1'b0, `SCPM_H_STAT_ADR, 32'h0);
    endtask
    task automatic t_boot();
        ahb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk(hresp, 1'b0);
        dcmd(1'b1, `SCPM_RANGE_ADR, 8'h00);
        chk(rd[15:8], `SCPM_RANGE_RST);
        dcmd(1'b1, `SCPM_POWER_ADR, 8'h00);
        chk(rd[15:8], `SCPM_POWER_RST);
        chk(u_scpm_if.second_irq_pin, 1'b0);
    endtask
    task automatic t_intmode();
        logic [31:0] c0;
        dcmd(1'b0, `SCPM_RANGE_ADR, 8'hC1);
        dcmd(1'b0, `SCPM_POWER_ADR, 8'h00);
        lwait(1);
        chk(measuring_ff, 1'b1);
        ahb(1'b0, `SCPM_H_RDYCNT_ADR, 32'h0);
        c0 = rd;
        lwait(96);
        ahb(1'b0, `SCPM_H_RDYCNT_ADR, 32'h0);
        chk(rd - c0 > 32'd3, 1'b1);
        chk(u_scpm_if.second_irq_pin, 1'b0);
        dcmd(1'b0, `SCPM_INTMAP_ADR, 8'h10);
        chk(rd[1], 1'b0);
        lwait(40);
        chk(u_scpm_if.second_irq_pin, !u_scpm_if.sample_ready_pin);
    endtask
    task automatic t_lock();
        dcmd(1'b0, `SCPM_SYNC_ADR, 8'h01);
        chk(rd[1], 1'b1);
        dcmd(1'b0, `SCPM_FILTER_ADR, 8'h35);
        dcmd(1'b1, `SCPM_FILTER_ADR, 8'h00);
        chk(rd[15:8], 8'h30);
        dcmd(1'b0, `SCPM_DIAG_ADR, 8'h03);
        chk(rd[1], 1'b0);
        dcmd(1'b0, `SCPM_POWER_ADR, 8'h01);
    endtask
    task automatic t_syncin();
        dcmd(1'b0, `SCPM_INTMAP_ADR, 8'h00);
        dcmd(1'b0, `SCPM_SYNC_ADR, 8'h02);
        lwait(2);
        chk(u_scpm_if.rdy_dev_oe_n, 1'b1);
        chk(u_scpm_if.irq2_dev_oe_n, 1'b0);
        dcmd(1'b0, `SCPM_POWER_ADR, 8'h01);
    endtask
    task automatic t_extclk();
        dcmd(1'b0, `SCPM_INTMAP_ADR, 8'h10);
        dcmd(1'b0, `SCPM_SYNC_ADR, 8'h05);
        lwait(2);
        chk(u_scpm_if.irq2_dev_oe_n, 1'b1);
        dcmd(1'b0, `SCPM_POWER_ADR, 8'h00);
        lwait(40);
        chk(data_out_ff, 8'h00);
        ahb(1'b1, `SCPM_H_CTRL_ADR, 32'h5);
        lwait(80);
        chk(data_out_ff != 8'h00, 1'b1);
        chk(u_scpm_if.second_irq_pin, u_scpm_if.irq2_host_o);
        dcmd(1'b1, `SCPM_STATUS_ADR, 8'h00);
        chk(rd[9], 1'b0);
        ahb(1'b1, `SCPM_H_CTRL_ADR, 32'h7);
        ahb(1'b0, `SCPM_H_STAT_ADR, 32'h0);
        chk(rd[`SCPM_ST_STROBE], 1'b1);
        lwait(50);
        dcmd(1'b1, `SCPM_STATUS_ADR, 8'h00);
        chk(rd[9], 1'b1);
    endtask
    initial begin
        err_count = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        hsel = 1'b1;
        hwrite = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        lwait(4);
        t_boot();
        t_intmode();
        t_lock();
        t_syncin();
        t_extclk();
        results();
    end
    initial begin
        #1000000;
        err_count++;
        results();
    end
endmodule
